// [verilog/lfdps_defs.svh]
// Purpose: Named constants for the LF driver operating-state control.
// Assumes: Included by the design module and the testbench.
// Notes:   Counts of oscillator periods are taken at the filtered oscillator input.
`ifndef LFDPS_DEFS_SVH
`define LFDPS_DEFS_SVH

// Serial command opcodes, first byte of a frame.
`define LFDPS_CMD_STATUS    8'h00
`define LFDPS_CMD_FLT_CLR   8'h11
`define LFDPS_CMD_MOD_STOP  8'h21
`define LFDPS_CMD_PWR_DOWN  8'h41
`define LFDPS_CMD_CFG1_WR   8'h04
`define LFDPS_CMD_LF_WR     8'h08

// Response bit positions.
`define LFDPS_RSP_SR_BIT    3'h7
`define LFDPS_RSP_RTS_BIT   3'h1

// Configuration field positions in the second byte.
`define LFDPS_CFG_IC_MSB    5
`define LFDPS_CFG_IC_LSB    2
`define LFDPS_CFG_AP_BIT    0

// Reset values of the configuration.
`define LFDPS_RST_COIL      4'h0
`define LFDPS_RST_PSK       1'b0

// Timing in oscillator periods, and the index of the last LF data bit.
`define LFDPS_DEB_OSC       12'h010
`define LFDPS_STBY_OSC      12'h800
`define LFDPS_BIT_OSC       6'h20
`define LFDPS_LF_BITS       3'h7

`endif

// [verilog/lfdps_pkg.sv]
// Purpose: Types shared by the LF driver operating-state control.
// Assumes: lfdps_defs.svh supplies the numeric constants.
// Notes:   State codes are one-hot.
package lfdps_pkg;

   // Operating states, one-hot.
   typedef enum logic [3:0] {
      LFDPS_PWRDN = 4'h1,
      LFDPS_DEBNC = 4'h2,
      LFDPS_STBY  = 4'h4,
      LFDPS_TMOUT = 4'h8
   } lfdps_state_t;

   // One received serial byte with its position in the frame.
   typedef struct packed {
      logic       first;
      logic [7:0] data;
   } lfdps_word_t;

   // Readiness bits returned in every response.
   typedef struct packed {
      logic sys_ready;
      logic mod_ready;
   } lfdps_stat_t;

endpackage

// [verilog/lfdps_power_ctrl.sv]
// Purpose: Operating-state control of an LF antenna driver with its serial command port.
// Assumes: sys_clk 100 MHz; serial_clk is the link clock, mode 0, MSB first in, LSB first out.
// Notes:   Pins from outside pass three flip-flops; a level counts when stages two and three agree.
// Function
// - After reset the device sits in power-down with only configuration kept.
// - Only asserting serial select wakes the device from power-down.
// - Once awake the device stays in standby, oscillator on, awaiting commands.
// - Power-down returns only on external reset or command plus select release.
// - Writing LF data starts modulator, driver and supply until done, stop or fault.
// - Modulation runs independent of serial activity; running shown on output pin.
// - In power-down internal logic is held reset and driver is high impedance.
// - Wake needs select held; full function granted only after oscillator build-up.
// - Every command response carries the two readiness bits.
// - First oscillator periods are debounced before internal functions power up.
// - Select release after power-down command starts a 2048 oscillator period timer.
// - While the standby timer runs the antenna driver stage is stopped.
// - Select asserted before timer expiry aborts power-down and keeps standby.
// - Timer expiry enters power-down, stops oscillator, drivers to high impedance.
// - Select release without command only disables the serial port.
// - External reset low acts like power-on reset: defaults and power-down.
// - Antenna current setpoint selectable in 16 steps.
// - Modulator supports ASK and PSK with carrier phase inversion.
// - System-ready bit reads 0 when not ready and 1 when ready.
// - Modulator-ready bit reads 0 when busy and 1 when ready.
// - Power-down command takes effect only on later select release.
`timescale 1ns/100ps
`include "lfdps_defs.svh"

module lfdps_power_ctrl (
   input  wire logic        sys_clk,                // System clock, 100 MHz.
   input  wire logic        rst_b,                  // External reset, active low.
   input  wire logic        serial_clk,             // Serial link clock.
   input  wire logic        serial_select_b,        // Serial select, active low.
   input  wire logic        serial_data_in,         // Serial data from controller.
   input  wire logic        oscillator_input,       // Oscillator clock pin.
   input  wire logic        driver_fault,           // Driver fault indication, high.
   output logic             serial_data_out,        // Serial response data.
   output logic             serial_data_out_oe_b,   // Response output enable, low drives.
   output logic             osc_enable,             // Oscillator running request.
   output logic             system_ready_bit,       // Full function granted.
   output logic             modulator_ready_out,    // Modulator can accept data.
   output logic             fault_memory_out,       // Stored driver fault.
   output logic             driver_enable,          // Antenna driver and supply active.
   output logic             driver_hiz,             // Driver stages high impedance.
   output logic             carrier_on,             // Carrier gated on.
   output logic             carrier_invert,         // Carrier phase inverted.
   output logic [3:0]       coil_current,           // Antenna current setpoint.
   output logic             modulation_running_out  // Modulator transmitting.
);
   import lfdps_pkg::*;

   logic                link_rst_b;
   logic [2:0]          rx_cnt;
   logic [6:0]          rx_shift;
   logic                rx_second;
   lfdps_word_t         rx_word;
   logic                rx_tgl;
   logic [1:0]          stat_hold;

   // The link logic is cleared whenever select is inactive, so each frame starts clean.
   assign link_rst_b = rst_b & ~serial_select_b;

   // Shift in on rising edges and count bits and bytes of the frame.
   always_ff @(posedge serial_clk or negedge link_rst_b) begin
      if (!link_rst_b) begin
         rx_cnt    <= 3'h0;
         rx_shift  <= 7'h00;
         rx_second <= 1'b0;
      end else begin
         rx_cnt   <= rx_cnt + 3'h1;
         rx_shift <= {rx_shift[5:0], serial_data_in};
         if (rx_cnt == 3'h7) begin
            rx_second <= 1'b1;
         end
      end
   end

   // Capture a whole byte and flag it by a toggle; held until the next byte.
   always_ff @(posedge serial_clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_word <= '0;
         rx_tgl  <= 1'b0;
      end else if (!serial_select_b && rx_cnt == 3'h7) begin
         rx_word <= '{first: ~rx_second, data: {rx_shift, serial_data_in}};
         rx_tgl  <= ~rx_tgl;
      end
   end

   // Response bit k leaves on the falling edge after k rising edges, LSB first.
   // It reads the system-side snapshot, frozen from shortly after select falls.
   always_ff @(negedge serial_clk or negedge link_rst_b) begin
      if (!link_rst_b) begin
         serial_data_out <= 1'b0;
      end else if (rx_cnt == `LFDPS_RSP_SR_BIT) begin
         serial_data_out <= stat_hold[1];
      end else if (rx_cnt == `LFDPS_RSP_RTS_BIT) begin
         serial_data_out <= stat_hold[0];
      end else begin
         serial_data_out <= 1'b0;
      end
   end

   logic [2:0]          pin_in;
   logic [2:0]          pin_s1;
   logic [2:0]          pin_s2;
   logic [2:0]          pin_s3;
   logic [2:0]          pin_lvl;
   logic                tgl_s1;
   logic                tgl_s2;
   logic                tgl_s3;
   logic                sel_act;
   logic                sel_prev;
   logic                osc_prev;
   logic                osc_tick;
   logic                fault_now;
   logic                byte_evt;
   lfdps_state_t        state;
   logic [11:0]         osc_cnt;
   logic                pd_pending;
   logic                want_cfg;
   logic                want_lf;
   logic [7:0]          lf_buf;
   logic [2:0]          lf_bit;
   logic [5:0]          bit_cnt;
   logic                lf_load;
   logic                mod_stop;
   logic                psk_mode;

   // Pins from outside: select (inverted to active high), oscillator, fault.
   assign pin_in = {driver_fault, oscillator_input, ~serial_select_b};

   // Three-stage input filters; a level is taken once stages two and three agree.
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_pin
         always_ff @(posedge sys_clk or negedge rst_b) begin
            if (!rst_b) begin
               pin_s1[gi]  <= 1'b0;
               pin_s2[gi]  <= 1'b0;
               pin_s3[gi]  <= 1'b0;
               pin_lvl[gi] <= 1'b0;
            end else begin
               pin_s1[gi] <= pin_in[gi];
               pin_s2[gi] <= pin_s1[gi];
               pin_s3[gi] <= pin_s2[gi];
               if (pin_s2[gi] == pin_s3[gi]) begin
                  pin_lvl[gi] <= pin_s3[gi];
               end
            end
         end
      end
   endgenerate

   assign sel_act   = pin_lvl[0];
   assign fault_now = pin_lvl[2];
   assign osc_tick  = pin_lvl[1] & ~osc_prev & osc_enable;
   assign byte_evt  = tgl_s3 ^ tgl_s2;

   // Byte toggle synchroniser and edge memories.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         tgl_s1   <= 1'b0;
         tgl_s2   <= 1'b0;
         tgl_s3   <= 1'b0;
         sel_prev <= 1'b0;
         osc_prev <= 1'b0;
      end else begin
         tgl_s1   <= rx_tgl;
         tgl_s2   <= tgl_s1;
         tgl_s3   <= tgl_s2;
         sel_prev <= sel_act;
         osc_prev <= pin_lvl[1];
      end
   end

   // Operating state sequence.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state   <= LFDPS_PWRDN;
         osc_cnt <= 12'h000;
      end else begin
         case (state)
            LFDPS_PWRDN: begin
               osc_cnt <= 12'h000;
               if (sel_act) begin
                  state <= LFDPS_DEBNC;
               end
            end
            LFDPS_DEBNC: begin
               if (!sel_act) begin
                  state <= LFDPS_PWRDN;
               end else if (osc_tick && osc_cnt == `LFDPS_DEB_OSC - 12'h001) begin
                  state   <= LFDPS_STBY;
                  osc_cnt <= 12'h000;
               end else if (osc_tick) begin
                  osc_cnt <= osc_cnt + 12'h001;
               end
            end
            LFDPS_STBY: begin
               osc_cnt <= 12'h000;
               if (sel_prev && !sel_act && pd_pending) begin
                  state <= LFDPS_TMOUT;
               end
            end
            LFDPS_TMOUT: begin
               if (sel_act) begin
                  state <= LFDPS_STBY;
               end else if (osc_tick && osc_cnt == `LFDPS_STBY_OSC - 12'h001) begin
                  state <= LFDPS_PWRDN;
               end else if (osc_tick) begin
                  osc_cnt <= osc_cnt + 12'h001;
               end
            end
            default: begin
               state <= LFDPS_PWRDN;
            end
         endcase
      end
   end

   // Command decode: pending power-down, configuration and LF data requests.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pd_pending   <= 1'b0;
         want_cfg     <= 1'b0;
         want_lf      <= 1'b0;
         coil_current <= `LFDPS_RST_COIL;
         carrier_invert <= 1'b0;
      end else begin
         if (state == LFDPS_PWRDN || (state == LFDPS_TMOUT && sel_act)) begin
            pd_pending <= 1'b0;
         end else if (byte_evt && rx_word.first && system_ready_bit &&
                      rx_word.data == `LFDPS_CMD_PWR_DOWN) begin
            pd_pending <= 1'b1;
         end
         if (byte_evt && rx_word.first) begin
            want_cfg <= (rx_word.data == `LFDPS_CMD_CFG1_WR);
            want_lf  <= (rx_word.data == `LFDPS_CMD_LF_WR);
         end else if (byte_evt) begin
            want_cfg <= 1'b0;
            want_lf  <= 1'b0;
         end
         if (byte_evt && !rx_word.first && want_cfg && system_ready_bit) begin
            coil_current <= rx_word.data[`LFDPS_CFG_IC_MSB:`LFDPS_CFG_IC_LSB];
         end
         carrier_invert <= modulation_running_out && psk_mode && lf_buf[lf_bit];
      end
   end

   // Modulation mode bit, kept through power-down, cleared by reset only.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         psk_mode <= `LFDPS_RST_PSK;
      end else if (byte_evt && !rx_word.first && want_cfg && system_ready_bit) begin
         psk_mode <= rx_word.data[`LFDPS_CFG_AP_BIT];
      end
   end

   assign lf_load  = byte_evt && !rx_word.first && want_lf && modulator_ready_out;
   assign mod_stop = byte_evt && rx_word.first && rx_word.data == `LFDPS_CMD_MOD_STOP;

   // Modulator: sends the buffered byte LSB first, one bit per bit period.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         modulation_running_out <= 1'b0;
         lf_buf  <= 8'h00;
         lf_bit  <= 3'h0;
         bit_cnt <= 6'h00;
      end else if (state != LFDPS_STBY || mod_stop || fault_now) begin
         modulation_running_out <= 1'b0;
         bit_cnt <= 6'h00;
      end else if (lf_load) begin
         lf_buf  <= rx_word.data;
         lf_bit  <= 3'h0;
         bit_cnt <= 6'h00;
         modulation_running_out <= 1'b1;
      end else if (modulation_running_out && osc_tick) begin
         if (bit_cnt == `LFDPS_BIT_OSC - 6'h01) begin
            bit_cnt <= 6'h00;
            if (lf_bit == `LFDPS_LF_BITS) begin
               modulation_running_out <= 1'b0;
            end else begin
               lf_bit <= lf_bit + 3'h1;
            end
         end else begin
            bit_cnt <= bit_cnt + 6'h01;
         end
      end
   end

   // Fault memory: a new fault wins over a clear command in the same cycle.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         fault_memory_out <= 1'b0;
      end else if (fault_now && state != LFDPS_PWRDN) begin
         fault_memory_out <= 1'b1;
      end else if (state == LFDPS_PWRDN ||
                   (byte_evt && rx_word.first && rx_word.data == `LFDPS_CMD_FLT_CLR)) begin
         fault_memory_out <= 1'b0;
      end
   end

   // Registered status, driver controls and the readiness snapshot for the link.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         osc_enable           <= 1'b0;
         system_ready_bit     <= 1'b0;
         modulator_ready_out  <= 1'b0;
         driver_enable        <= 1'b0;
         driver_hiz           <= 1'b1;
         carrier_on           <= 1'b0;
         serial_data_out_oe_b <= 1'b1;
         stat_hold            <= 2'h0;
      end else begin
         osc_enable          <= (state != LFDPS_PWRDN) || sel_act;
         system_ready_bit    <= (state == LFDPS_STBY) ||
                                (state == LFDPS_TMOUT);
         modulator_ready_out <= (state == LFDPS_STBY) && !modulation_running_out &&
                                !lf_load && !fault_memory_out && !fault_now;
         driver_enable       <= modulation_running_out;
         driver_hiz          <= (state == LFDPS_PWRDN) ||
                                (state == LFDPS_DEBNC);
         carrier_on          <= modulation_running_out &&
                                (psk_mode || lf_buf[lf_bit]);
         serial_data_out_oe_b <= ~sel_act;
         if (!sel_act) begin
            stat_hold <= {system_ready_bit, modulator_ready_out};
         end
      end
   end

endmodule

// [verification/lfdps_ctrl_props.sv]
// Purpose: Concurrent checks on the ports of the operating-state control.
// Assumes: Every check runs in the system clock domain.
// Notes:   Bound to every instance of the design module.
`timescale 1ns/100ps
module lfdps_ctrl_props (
   input wire logic sys_clk,                // System clock.
   input wire logic rst_b,                  // External reset, active low.
   input wire logic serial_select_b,        // Serial select, active low.
   input wire logic driver_fault,           // Driver fault pin.
   input wire logic serial_data_out_oe_b,   // Response enable, low drives.
   input wire logic osc_enable,             // Oscillator request.
   input wire logic system_ready_bit,       // Full function granted.
   input wire logic modulator_ready_out,    // Modulator can accept data.
   input wire logic fault_memory_out,       // Stored fault.
   input wire logic driver_enable,          // Driver and supply active.
   input wire logic driver_hiz,             // Driver stages high impedance.
   input wire logic carrier_on,             // Carrier gated on.
   input wire logic carrier_invert,         // Carrier phase inverted.
   input wire logic modulation_running_out  // Modulator transmitting.
);
   import lfdps_pkg::*;
   // All checks share the system clock and drop out during reset.
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   // A high impedance driver never drives the antenna.
   a_hiz_no_drive: assert property (driver_hiz |-> !driver_enable && !modulation_running_out)
      else $error("driver active while high impedance");
   // The driver stage follows the running modulator.
   a_drive_follows: assert property (modulation_running_out |=> driver_enable)
      else $error("driver not enabled while running");
   // Two idle cycles leave driver and carrier off.
   a_idle_off: assert property (!modulation_running_out [*2] |-> !driver_enable && !carrier_on)
      else $error("driver or carrier on while idle");
   // Readiness implies an awake device.
   a_ready_awake: assert property (system_ready_bit |-> !driver_hiz && osc_enable)
      else $error("ready while asleep");
   // The modulator is ready only in a ready system without stored fault.
   a_modrdy_sys: assert property (modulator_ready_out |-> system_ready_bit && !fault_memory_out)
      else $error("modulator ready in wrong state");
   // A running modulator does not report ready.
   a_busy_unready: assert property (modulation_running_out ##1 modulation_running_out
                                    |-> !modulator_ready_out)
      else $error("modulator ready while running");
   // A held fault stops the modulator.
   a_fault_stops: assert property (driver_fault [*8] |=> !modulation_running_out)
      else $error("modulation continues under fault");
   // Phase inversion only happens with the carrier on.
   a_invert_on: assert property (carrier_invert |-> carrier_on)
      else $error("carrier inverted while off");
   // The oscillator starts only with select asserted.
   a_wake_select: assert property ($rose(osc_enable) |-> !serial_select_b)
      else $error("woke without select");
   // Leaving readiness ends in power-down with the oscillator stopped.
   a_pd_entry: assert property ($fell(system_ready_bit) |-> ##[0:2] (driver_hiz && !osc_enable))
      else $error("power-down entry incomplete");
   // A released select releases the response line.
   a_oe_release: assert property (serial_select_b [*8] |-> serial_data_out_oe_b)
      else $error("response driven without select");

   // Main scenarios.
   c_run: cover property ($rose(modulation_running_out));
   c_pd: cover property ($fell(system_ready_bit));
   c_fault: cover property ($rose(fault_memory_out));
endmodule

bind lfdps_power_ctrl lfdps_ctrl_props lfdps_ctrl_props_i (
   .sys_clk(sys_clk), .rst_b(rst_b), .serial_select_b(serial_select_b),
   .driver_fault(driver_fault), .serial_data_out_oe_b(serial_data_out_oe_b),
   .osc_enable(osc_enable), .system_ready_bit(system_ready_bit),
   .modulator_ready_out(modulator_ready_out), .fault_memory_out(fault_memory_out),
   .driver_enable(driver_enable), .driver_hiz(driver_hiz), .carrier_on(carrier_on),
   .carrier_invert(carrier_invert), .modulation_running_out(modulation_running_out));

// [verification/lfdps_mcu_model.sv]
// Purpose: Serial bus master standing in for the microcontroller.
// Assumes: Mode 0 link with an 80 ns clock that runs only inside frames.
// Notes:   The data line shows the inverse of its last bit between frames.
`timescale 1ns/100ps
module lfdps_mcu_model (
   output logic      serial_clk,       // Link clock, idle low.
   output logic      serial_select_b,  // Select, active low.
   output logic      serial_data_in,   // Command bits to the device.
   input  wire logic serial_miso       // Response line level.
);
   import lfdps_pkg::*;
   // Idle levels from time zero.
   initial begin
      serial_clk = 1'b0;
      serial_select_b = 1'b1;
      serial_data_in = 1'b0;
   end
   // One frame of n bits, MSB first, bytes 1 us apart, response LSB first.
   task automatic frame(input logic [15:0] bits, input int n, input int lead,
                        output logic [7:0] rsp);
      rsp = 8'h00;
      serial_select_b = 1'b0;
      #(200 + lead); // Select held unbroken through the wake debounce.
      for (int i = 0; i < n; i++) begin
         serial_data_in = bits[15 - i];
         #40;
         serial_clk = 1'b1;
         if (i < 8) rsp[i] = serial_miso;
         #40;
         serial_clk = 1'b0;
         if (i == 7) #1000;
      end
      #400;
      serial_select_b = 1'b1;
      serial_data_in = ~serial_data_in;
      #1200;
   endtask
endmodule

// [verification/lfdps_power_ctrl_tb.sv]
// Purpose: Self-checking bench for the LF driver operating-state control.
// Assumes: The oscillator pin toggles with a 42 ns period only while requested.
// Notes:   Each scenario drives the block and judges the result itself.
`timescale 1ns/100ps
`include "lfdps_defs.svh"
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin err_count++; \
   $display("unexpected %s: expected %h seen %h", nm, ex, got); end end
module lfdps_power_ctrl_tb;
   import lfdps_pkg::*;
   logic       sys_clk = 1'b0;
   logic       rst_b, oscillator_input, driver_fault, serial_clk, serial_select_b;
   logic       serial_data_in, serial_data_out, serial_data_out_oe_b, osc_enable;
   logic       system_ready_bit, modulator_ready_out, fault_memory_out, driver_enable;
   logic       driver_hiz, carrier_on, carrier_invert, modulation_running_out;
   logic [3:0] coil_current;
   logic [7:0] rsp;
   wire        serial_miso;
   int         err_count = 0;
   int         check_count = 0;

   // System clock and an oscillator that runs only while requested.
   always #5 sys_clk = ~sys_clk;
   always #21 oscillator_input = (osc_enable === 1'b1) ? ~oscillator_input : 1'b0;
   // Response line level seen by the master.
   assign serial_miso = serial_data_out_oe_b ? 1'bz : serial_data_out;

   lfdps_mcu_model lfdps_mcu_model_i (.serial_clk(serial_clk), .serial_select_b(serial_select_b),
      .serial_data_in(serial_data_in), .serial_miso(serial_miso));
   lfdps_power_ctrl lfdps_power_ctrl_i (.sys_clk(sys_clk), .rst_b(rst_b),
      .serial_clk(serial_clk), .serial_select_b(serial_select_b),
      .serial_data_in(serial_data_in), .oscillator_input(oscillator_input),
      .driver_fault(driver_fault), .serial_data_out(serial_data_out),
      .serial_data_out_oe_b(serial_data_out_oe_b), .osc_enable(osc_enable),
      .system_ready_bit(system_ready_bit), .modulator_ready_out(modulator_ready_out),
      .fault_memory_out(fault_memory_out), .driver_enable(driver_enable),
      .driver_hiz(driver_hiz), .carrier_on(carrier_on), .carrier_invert(carrier_invert),
      .coil_current(coil_current), .modulation_running_out(modulation_running_out));

   task automatic finish_test();
      if (err_count == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic send(input logic [15:0] bits, input int n, input int lead);
      lfdps_mcu_model_i.frame(bits, n, lead, rsp);
   endtask
   // Quiet power-down levels.
   task automatic t_reset();
      `CHK("driver_hiz", 1'b1, driver_hiz)
      `CHK("system_ready", 1'b0, system_ready_bit)
      `CHK("running", 1'b0, modulation_running_out)
      `CHK("osc_enable", 1'b0, osc_enable)
   endtask
   // Wake with select held, then read the status bits.
   task automatic t_wake();
      send({`LFDPS_CMD_STATUS, 8'h00}, 8, 2000);
      send({`LFDPS_CMD_STATUS, 8'h00}, 8, 0);
      `CHK("status", 8'h82, rsp)
      `CHK("system_ready", 1'b1, system_ready_bit)
      `CHK("osc_enable", 1'b1, osc_enable)
      `CHK("driver_hiz", 1'b0, driver_hiz)
   endtask
   // Configure, send one LF byte and follow its bits while select drops mid-run.
   task automatic t_mod(input logic psk, input logic [7:0] d);
      send({`LFDPS_CMD_CFG1_WR, 2'b00, psk, 3'h5, 1'b0, psk}, 16, 0);
      `CHK("coil", {psk, 3'h5}, coil_current)
      fork
         send({`LFDPS_CMD_LF_WR, d}, 16, 0);
         begin
            repeat (4000) if (modulation_running_out !== 1'b1) @(negedge sys_clk);
            #672;
            for (int i = 0; i < 8; i++) begin
               `CHK("carrier_on", psk | d[i], carrier_on)
               `CHK("carrier_inv", psk & d[i], carrier_invert)
               `CHK("driver_en", 1'b1, driver_enable)
               #1344;
            end
            `CHK("running", 1'b0, modulation_running_out)
         end
      join
   endtask
   // Stop command, fault, refused data and fault clearing.
   task automatic t_stop_fault();
      send({`LFDPS_CMD_LF_WR, 8'hff}, 16, 0);
      `CHK("running", 1'b1, modulation_running_out)
      send({`LFDPS_CMD_MOD_STOP, 8'h00}, 8, 0);
      `CHK("running", 1'b0, modulation_running_out)
      send({`LFDPS_CMD_LF_WR, 8'hff}, 16, 0);
      @(negedge sys_clk) driver_fault = 1'b1;
      wait_cyc(20);
      `CHK("running", 1'b0, modulation_running_out)
      `CHK("fault_mem", 1'b1, fault_memory_out)
      driver_fault = 1'b0;
      send({`LFDPS_CMD_LF_WR, 8'hff}, 16, 0);
      `CHK("running", 1'b0, modulation_running_out)
      send({`LFDPS_CMD_STATUS, 8'h00}, 8, 0);
      `CHK("status", 8'h80, rsp)
      send({`LFDPS_CMD_FLT_CLR, 8'h00}, 8, 0);
      send({`LFDPS_CMD_STATUS, 8'h00}, 8, 0);
      `CHK("status", 8'h82, rsp)
   endtask
   // Power-down command, timer running, then select returns and aborts it.
   task automatic t_pd_abort();
      send({`LFDPS_CMD_LF_WR, 8'hff}, 16, 0);
      send({`LFDPS_CMD_PWR_DOWN, 8'h00}, 8, 0);
      `CHK("running", 1'b0, modulation_running_out)
      `CHK("driver_en", 1'b0, driver_enable)
      `CHK("system_ready", 1'b1, system_ready_bit)
      send({`LFDPS_CMD_STATUS, 8'h00}, 8, 0);
      wait_cyc(9500);
      `CHK("system_ready", 1'b1, system_ready_bit)
      `CHK("driver_hiz", 1'b0, driver_hiz)
   endtask
   // Full power-down: 2048 oscillator periods of 4.2 cycles each.
   task automatic t_pd();
      send({`LFDPS_CMD_PWR_DOWN, 8'h00}, 8, 0);
      wait_cyc(8300);
      `CHK("system_ready", 1'b1, system_ready_bit)
      wait_cyc(600);
      `CHK("system_ready", 1'b0, system_ready_bit)
      `CHK("driver_hiz", 1'b1, driver_hiz)
      `CHK("osc_enable", 1'b0, osc_enable)
   endtask
   // External reset while awake and configured restores defaults.
   task automatic t_ext_reset();
      send({`LFDPS_CMD_STATUS, 8'h00}, 8, 2000);
      send({`LFDPS_CMD_CFG1_WR, 8'h25}, 16, 0);
      `CHK("coil", 4'h9, coil_current)
      @(negedge sys_clk) rst_b = 1'b0;
      wait_cyc(10);
      t_reset();
      `CHK("coil", 4'h0, coil_current)
      rst_b = 1'b1;
      wait_cyc(10);
   endtask

   // Main sequence.
   initial begin
      rst_b = 1'b1;
      driver_fault = 1'b0;
      oscillator_input = 1'b0;
      // A real falling reset edge also clears the idle link-side flops.
      #1;
      rst_b = 1'b0;
      wait_cyc(5);
      t_reset();
      wait_cyc(5);
      rst_b = 1'b1;
      wait_cyc(20);
      t_reset();
      t_wake();
      t_mod(1'b1, 8'ha5);
      t_mod(1'b0, 8'h5a);
      t_stop_fault();
      t_pd_abort();
      t_pd();
      t_ext_reset();
      finish_test();
   end
   // Watchdog against a hang.
   initial begin
      #600000;
      err_count++;
      finish_test();
   end
endmodule
